//--- verilog/scgsr_pkg.sv
// Constants of the system-control block: paged register map, field positions,
// reset values, calendar limits and timebase figures.
// Assumes a 10 MHz reference clock and 16-bit SPI frames, MSB first.
package scgsr_pkg;

   // Timebase
   localparam int CLK_FREQ_HZ = 10_000_000;
   localparam int TICK_PERIOD_S = 1;
   localparam int TICK_CYCLES = TICK_PERIOD_S * CLK_FREQ_HZ;

   // Serial frame
   localparam int FRAME_BITS = 16;
   localparam logic [4:0] FRAME_LAST = 5'h0F;
   localparam int WR_BIT = 15;
   // Idle levels of select, serial clock and data in, as {cs_n, sclk, din}
   localparam logic [2:0] SPI_IDLE = 3'h6;

   // Pages and word addresses
   localparam logic [7:0] PAGE_DATA = 8'h00;
   localparam logic [7:0] PAGE_USER = 8'h02;
   localparam logic [7:0] PAGE_CTRL = 8'h03;
   localparam logic [6:0] ADDR_PAGE = 7'h00;
   localparam logic [6:0] ADDR_FUNC = 7'h06;
   localparam logic [6:0] ADDR_PIN = 7'h08;
   localparam logic [6:0] ADDR_CONFIG = 7'h0A;
   localparam logic [6:0] ADDR_SLEEP = 7'h10;
   localparam logic [6:0] ADDR_SCRATCH1 = 7'h74;
   localparam logic [6:0] ADDR_SCRATCH2 = 7'h76;
   localparam logic [6:0] ADDR_SCRATCH3 = 7'h78;
   localparam logic [6:0] ADDR_SCRATCH4 = 7'h7A;
   localparam logic [6:0] ADDR_TIME_MS = 7'h78;
   localparam logic [6:0] ADDR_TIME_DH = 7'h7A;
   localparam logic [6:0] ADDR_TIME_YM = 7'h7C;

   // Reset values
   localparam logic [15:0] FUNC_RESET = 16'h000D;
   localparam logic [7:0] PAGE_RESET = 8'h00;

   // Pin function select fields
   localparam int FN_DR_EN = 3;
   localparam int FN_DR_SEL = 0;
   localparam int FN_SYNC_EN = 7;
   localparam int FN_SYNC_SEL = 4;
   localparam int FN_ALM_EN = 11;
   localparam int FN_ALM_SEL = 8;

   // Sleep control fields
   localparam int SLP_SLEEP_BIT = 8;
   localparam int SLP_PDOWN_BIT = 9;

   // Calendar limits
   localparam logic [5:0] SEC_MAX = 6'h3B;
   localparam logic [5:0] MIN_MAX = 6'h3B;
   localparam logic [5:0] HOUR_MAX = 6'h17;
   localparam logic [4:0] DAY_MAX = 5'h1F;
   localparam logic [4:0] DAY_30 = 5'h1E;
   localparam logic [4:0] DAY_29 = 5'h1D;
   localparam logic [4:0] DAY_28 = 5'h1C;
   localparam logic [3:0] MON_MAX = 4'hC;
   localparam logic [3:0] MON_FEB = 4'h2;
   localparam logic [3:0] MON_APR = 4'h4;
   localparam logic [3:0] MON_JUN = 4'h6;
   localparam logic [3:0] MON_SEP = 4'h9;
   localparam logic [3:0] MON_NOV = 4'hB;
   localparam logic [6:0] YEAR_MAX = 7'h63;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_ARM = 2'b01,
      ST_SLEEP = 2'b11,
      ST_PDOWN = 2'b10
   } scgsr_state_t;

endpackage

//--- verilog/scgsr_spi_if.sv
// Frame carrier between the serial slave and the register bank.
// Assumes both ends run on the reference clock.
`timescale 1ns/100ps
interface scgsr_spi_if;
   logic frame_valid;
   logic [15:0] frame_word;
   logic cs_fall;
   logic cs_rise;
   logic [15:0] rd_data;

   modport slave (output frame_valid, output frame_word, output cs_fall,
                  output cs_rise, input rd_data);
   modport regs (input frame_valid, input frame_word, input cs_fall,
                 input cs_rise, output rd_data);
endinterface

//--- verilog/scgsr_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes inputs are asynchronous to the reference clock.
`timescale 1ns/100ps
module scgsr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_clk,         // Reference clock
   input wire logic i_rst_n,       // Async reset, active low
   input wire logic [W-1:0] i_d,   // Raw pin levels
   output logic [W-1:0] o_q        // Synchronised levels
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // Starting at the pin's idle level avoids a false edge after reset
         meta_ff <= RST_VAL;
         o_q <= RST_VAL;
      end else begin
         meta_ff <= i_d;
         o_q <= meta_ff;
      end
   end
endmodule

//--- verilog/scgsr_spi_slave.sv
// Oversampled SPI slave, mode 3, 16-bit frames, MSB first.
// Assumes synchronised chip select, clock and data, and SCLK well below 5 MHz.
`timescale 1ns/100ps
module scgsr_spi_slave (
   input wire logic i_clk,         // Reference clock
   input wire logic i_rst_n,       // Async reset, active low
   input wire logic i_cs_n,        // Synchronised chip select, active low
   input wire logic i_sclk,        // Synchronised serial clock
   input wire logic i_din,         // Synchronised serial data in
   output logic o_dout,            // Serial data out
   scgsr_spi_if.slave bus          // Frame carrier
);
   logic sclk_q_ff;
   logic cs_q_ff;
   logic [4:0] cnt_ff;
   logic [15:0] in_sh_ff;
   logic [15:0] out_sh_ff;

   wire sclk_rise = i_sclk & ~sclk_q_ff & ~i_cs_n;
   wire sclk_fall = ~i_sclk & sclk_q_ff & ~i_cs_n;
   wire cs_fall = cs_q_ff & ~i_cs_n;
   wire cs_rise = ~cs_q_ff & i_cs_n;
   wire last_bit = sclk_rise & (cnt_ff == scgsr_pkg::FRAME_LAST);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sclk_q_ff <= 1'b1;
         cs_q_ff <= 1'b1;
         cnt_ff <= '0;
         in_sh_ff <= '0;
         out_sh_ff <= '0;
         o_dout <= 1'b0;
         bus.frame_valid <= 1'b0;
         bus.frame_word <= '0;
         bus.cs_fall <= 1'b0;
         bus.cs_rise <= 1'b0;
      end else begin
         sclk_q_ff <= i_sclk;
         cs_q_ff <= i_cs_n;
         bus.cs_fall <= cs_fall;
         bus.cs_rise <= cs_rise;
         bus.frame_valid <= last_bit;
         if (cs_fall) begin
            cnt_ff <= '0;
            out_sh_ff <= bus.rd_data;
            o_dout <= bus.rd_data[scgsr_pkg::FRAME_BITS-1];
         end else begin
            if (sclk_rise) begin
               in_sh_ff <= {in_sh_ff[14:0], i_din};
               cnt_ff <= last_bit ? '0 : cnt_ff + 5'h01;
            end
            // The first falling edge precedes any sample, so MSB is held through it
            if (sclk_fall && cnt_ff != '0) begin
               out_sh_ff <= {out_sh_ff[14:0], 1'b0};
               o_dout <= out_sh_ff[14];
            end
         end
         if (last_bit) begin
            bus.frame_word <= {in_sh_ff[14:0], i_din};
         end
      end
   end
endmodule

//--- verilog/scgsr_top.sv
// System-control register bank: pins, sleep control, scratch words and clock.
// Assumes a host SPI master using paged byte writes and next-frame reads.
`timescale 1ns/100ps
module scgsr_top #(
   parameter int P_TICK_CYCLES = scgsr_pkg::TICK_CYCLES
) (
   input wire logic i_ref_clk,          // 10 MHz reference clock
   input wire logic i_rst_n,            // Async reset, active low
   input wire logic i_spi_cs_n,         // Chip select pin, active low
   input wire logic i_spi_sclk,         // Serial clock pin
   input wire logic i_spi_din,          // Serial data in pin
   output logic o_spi_dout,             // Serial data out pin
   input wire logic [3:0] i_gpio_in,    // General pin levels, pin one at bit 0
   output logic [3:0] o_gpio_out,       // General pin drive levels
   output logic [3:0] o_gpio_oe,        // General pin drive enables
   output logic o_sleep,                // Sleep mode active
   output logic o_power_down            // Power-down mode active
);
   scgsr_spi_if spi ();

   logic [2:0] spi_sync;
   logic [3:0] pin_sync;

   // Idle reset value keeps edge detectors quiet when reset is released
   scgsr_sync #(.W(3), .RST_VAL(scgsr_pkg::SPI_IDLE)) u_spi_sync (
      .i_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_d({i_spi_cs_n, i_spi_sclk, i_spi_din}),
      .o_q(spi_sync)
   );

   scgsr_sync #(.W(4)) u_pin_sync (
      .i_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_d(i_gpio_in),
      .o_q(pin_sync)
   );

   scgsr_spi_slave u_spi (
      .i_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_cs_n(spi_sync[2]),
      .i_sclk(spi_sync[1]),
      .i_din(spi_sync[0]),
      .o_dout(o_spi_dout),
      .bus(spi.slave)
   );

   function automatic logic [15:0] merge(input logic [15:0] old, input logic hi,
                                         input logic [7:0] d);
      merge = hi ? {d, old[7:0]} : {old[15:8], d};
   endfunction

   function automatic logic [3:0] pin_owner(input logic en, input logic [1:0] sel);
      pin_owner = en ? (4'h1 << sel) : 4'h0;
   endfunction

   function automatic logic [4:0] month_days(input logic [3:0] mon, input logic [6:0] yr);
      if (mon == scgsr_pkg::MON_FEB) begin
         month_days = (yr[1:0] == 2'b00) ? scgsr_pkg::DAY_29 : scgsr_pkg::DAY_28;
      end else if (mon == scgsr_pkg::MON_APR || mon == scgsr_pkg::MON_JUN ||
                   mon == scgsr_pkg::MON_SEP || mon == scgsr_pkg::MON_NOV) begin
         month_days = scgsr_pkg::DAY_30;
      end else begin
         month_days = scgsr_pkg::DAY_MAX;
      end
   endfunction

   // Registers
   logic [7:0] page_ff;
   logic [15:0] func_ff;
   logic [3:0] pin_dir_ff;
   logic [3:0] pin_lvl_ff;
   logic [7:0] slp_dur_ff;
   logic slp_req_ff;
   logic pd_req_ff;
   logic cal_mode_ff;
   logic [15:0] scratch_ff [4];
   logic [15:0] rd_ff;
   scgsr_pkg::scgsr_state_t state_ff;
   scgsr_pkg::scgsr_state_t nxt_state;
   logic [7:0] sleep_cnt_ff;
   logic [31:0] tick_cnt_ff;
   logic tick_ff;
   logic [5:0] sec_ff, min_ff, hour_ff;
   logic [4:0] day_ff;
   logic [3:0] mon_ff;
   logic [6:0] year_ff;
   logic [5:0] p_sec_ff, p_min_ff, p_hour_ff;
   logic [4:0] p_day_ff;
   logic [3:0] p_mon_ff;
   logic [6:0] p_year_ff;
   logic commit_ff;

   // Frame decode
   wire wr = spi.frame_valid & spi.frame_word[scgsr_pkg::WR_BIT];
   wire rd = spi.frame_valid & ~spi.frame_word[scgsr_pkg::WR_BIT];
   wire [6:0] fa = spi.frame_word[14:8];
   wire [7:0] wd = spi.frame_word[7:0];
   wire hi = fa[0];
   wire [6:0] wa = {fa[6:1], 1'b0};
   wire pg_ctrl = page_ff == scgsr_pkg::PAGE_CTRL;
   wire pg_user = page_ff == scgsr_pkg::PAGE_USER;
   wire pg_data = page_ff == scgsr_pkg::PAGE_DATA;
   wire we_page = wr & (wa == scgsr_pkg::ADDR_PAGE) & ~hi;
   wire we_func = wr & pg_ctrl & (wa == scgsr_pkg::ADDR_FUNC);
   wire we_pin = wr & pg_ctrl & (wa == scgsr_pkg::ADDR_PIN) & ~hi;
   wire we_cfg = wr & pg_ctrl & (wa == scgsr_pkg::ADDR_CONFIG) & ~hi;
   wire we_slp = wr & pg_ctrl & (wa == scgsr_pkg::ADDR_SLEEP);
   wire we_time = wr & pg_data & cal_mode_ff;
   wire we_ms = we_time & (wa == scgsr_pkg::ADDR_TIME_MS);
   wire we_dh = we_time & (wa == scgsr_pkg::ADDR_TIME_DH);
   wire we_ym = we_time & (wa == scgsr_pkg::ADDR_TIME_YM);
   wire [1:0] scr_idx = 2'(fa[2:1] - scgsr_pkg::ADDR_SCRATCH1[2:1]);
   wire scr_hit = (wa == scgsr_pkg::ADDR_SCRATCH1) | (wa == scgsr_pkg::ADDR_SCRATCH2) |
                  (wa == scgsr_pkg::ADDR_SCRATCH3) | (wa == scgsr_pkg::ADDR_SCRATCH4);
   wire we_scr = wr & pg_user & scr_hit;

   wire [3:0] dedicated =
      pin_owner(func_ff[scgsr_pkg::FN_DR_EN], func_ff[scgsr_pkg::FN_DR_SEL +: 2]) |
      pin_owner(func_ff[scgsr_pkg::FN_SYNC_EN], func_ff[scgsr_pkg::FN_SYNC_SEL +: 2]) |
      pin_owner(func_ff[scgsr_pkg::FN_ALM_EN], func_ff[scgsr_pkg::FN_ALM_SEL +: 2]);

   // Sleep sequencing
   wire leaving = (state_ff == scgsr_pkg::ST_SLEEP || state_ff == scgsr_pkg::ST_PDOWN) &&
                  nxt_state == scgsr_pkg::ST_RUN;
   wire wipe = leaving && state_ff == scgsr_pkg::ST_PDOWN;
   wire req_wr = we_slp & hi & (wd[0] | wd[1]);
   wire expire = tick_ff & (sleep_cnt_ff == 8'h01);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         scgsr_pkg::ST_RUN: begin
            if (req_wr) begin
               nxt_state = scgsr_pkg::ST_ARM;
            end
         end
         scgsr_pkg::ST_ARM: begin
            // entry waits for chip select high; sleep wins
            if (spi.cs_rise) begin
               nxt_state = slp_req_ff ? scgsr_pkg::ST_SLEEP : scgsr_pkg::ST_PDOWN;
            end
         end
         scgsr_pkg::ST_SLEEP, scgsr_pkg::ST_PDOWN: begin
            // wake on select fall; wake on countdown expiry
            if (spi.cs_fall || expire) begin
               nxt_state = scgsr_pkg::ST_RUN;
            end
         end
         default: begin
            nxt_state = scgsr_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= scgsr_pkg::ST_RUN;
         sleep_cnt_ff <= '0;
         o_sleep <= 1'b0;
         o_power_down <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         o_sleep <= nxt_state == scgsr_pkg::ST_SLEEP;
         o_power_down <= nxt_state == scgsr_pkg::ST_PDOWN;
         if (state_ff == scgsr_pkg::ST_ARM) begin
            sleep_cnt_ff <= slp_dur_ff;
         end else if (tick_ff && sleep_cnt_ff != '0) begin
            sleep_cnt_ff <= sleep_cnt_ff - 8'h01;
         end
      end
   end

   // volatile settings cleared at reset and after power-down only
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         page_ff <= scgsr_pkg::PAGE_RESET;
         func_ff <= scgsr_pkg::FUNC_RESET;
         pin_dir_ff <= '0;
         pin_lvl_ff <= '0;
         cal_mode_ff <= 1'b0;
      end else if (wipe) begin
         page_ff <= scgsr_pkg::PAGE_RESET;
         func_ff <= scgsr_pkg::FUNC_RESET;
         pin_dir_ff <= '0;
         pin_lvl_ff <= '0;
         cal_mode_ff <= 1'b0;
      end else begin
         if (we_page) begin
            page_ff <= wd;
         end
         if (we_func) begin
            func_ff <= merge(func_ff, hi, wd);
         end
         // direction low nibble, level high nibble
         if (we_pin) begin
            pin_dir_ff <= wd[3:0];
            pin_lvl_ff <= wd[7:4];
         end
         if (we_cfg) begin
            cal_mode_ff <= wd[0];
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         slp_dur_ff <= '0;
         slp_req_ff <= 1'b0;
         pd_req_ff <= 1'b0;
      end else if (wipe) begin
         slp_dur_ff <= '0;
         slp_req_ff <= 1'b0;
         pd_req_ff <= 1'b0;
      end else if (we_slp && !hi) begin
         slp_dur_ff <= wd;
      end else if (we_slp) begin
         slp_req_ff <= wd[scgsr_pkg::SLP_SLEEP_BIT - 8];
         pd_req_ff <= wd[scgsr_pkg::SLP_PDOWN_BIT - 8];
      end else if (leaving) begin
         slp_req_ff <= 1'b0;
         pd_req_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scratch_ff <= '{default: '0};
      end else if (wipe) begin
         scratch_ff <= '{default: '0};
      end else if (we_scr) begin
         scratch_ff[scr_idx] <= merge(scratch_ff[scr_idx], hi, wd);
      end
   end

   // dedicated pins are released from general drive
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_gpio_oe <= '0;
         o_gpio_out <= '0;
      end else begin
         o_gpio_oe <= pin_dir_ff & ~dedicated;
         o_gpio_out <= pin_lvl_ff;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= tick_cnt_ff == 32'(P_TICK_CYCLES - 1);
         tick_cnt_ff <= (tick_cnt_ff == 32'(P_TICK_CYCLES - 1)) ? '0 : tick_cnt_ff + 32'h1;
      end
   end

   // pending fields, armed by the year byte
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {p_sec_ff, p_min_ff, p_hour_ff} <= '0;
         {p_day_ff, p_mon_ff, p_year_ff} <= '0;
         commit_ff <= 1'b0;
      end else begin
         if (we_ms && !hi) p_sec_ff <= wd[5:0];
         if (we_ms && hi) p_min_ff <= wd[5:0];
         if (we_dh && !hi) p_hour_ff <= wd[5:0];
         if (we_dh && hi) p_day_ff <= wd[4:0];
         if (we_ym && !hi) p_mon_ff <= wd[3:0];
         // Year write wins over the tick that consumes an earlier commit
         if (we_ym && hi) begin
            p_year_ff <= wd[6:0];
            commit_ff <= 1'b1;
         end else if (tick_ff) begin
            commit_ff <= 1'b0;
         end
      end
   end

   // carry chain; calendar days and months start at one
   wire [4:0] day_lo = {4'h0, cal_mode_ff};
   wire [3:0] mon_lo = {3'h0, cal_mode_ff};
   wire [4:0] day_hi = cal_mode_ff ? month_days(mon_ff, year_ff) : scgsr_pkg::DAY_MAX;
   wire c_sec = sec_ff == scgsr_pkg::SEC_MAX;
   wire c_min = c_sec && min_ff == scgsr_pkg::MIN_MAX;
   wire c_hour = c_min && hour_ff == scgsr_pkg::HOUR_MAX;
   wire c_day = c_hour && day_ff >= day_hi;
   wire c_mon = c_day && mon_ff >= scgsr_pkg::MON_MAX;

   // cleared at reset; commit lands on the next tick
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {sec_ff, min_ff, hour_ff} <= '0;
         {day_ff, mon_ff, year_ff} <= '0;
      end else if (tick_ff && commit_ff) begin
         {sec_ff, min_ff, hour_ff} <= {p_sec_ff, p_min_ff, p_hour_ff};
         {day_ff, mon_ff, year_ff} <= {p_day_ff, p_mon_ff, p_year_ff};
      end else if (tick_ff) begin
         sec_ff <= c_sec ? '0 : sec_ff + 6'h01;
         if (c_sec) min_ff <= c_min ? '0 : min_ff + 6'h01;
         if (c_min) hour_ff <= c_hour ? '0 : hour_ff + 6'h01;
         if (c_hour) day_ff <= c_day ? day_lo : day_ff + 5'h01;
         if (c_day) mon_ff <= c_mon ? mon_lo : mon_ff + 4'h1;
         if (c_mon) year_ff <= (year_ff == scgsr_pkg::YEAR_MAX) ? '0 : year_ff + 7'h01;
      end
   end

   // level bits always show the synchronised pin levels
   wire [15:0] pin_word = {8'h00, pin_sync, pin_dir_ff};
   wire [15:0] slp_word = {6'h00, pd_req_ff, slp_req_ff, slp_dur_ff};
   wire [15:0] ms_word = {2'h0, min_ff, 2'h0, sec_ff};
   wire [15:0] dh_word = {3'h0, day_ff, 2'h0, hour_ff};
   wire [15:0] ym_word = {1'b0, year_ff, 4'h0, mon_ff};
   wire [15:0] rd_word =
      (wa == scgsr_pkg::ADDR_PAGE) ? {8'h00, page_ff} :
      (pg_ctrl && wa == scgsr_pkg::ADDR_FUNC) ? func_ff :
      (pg_ctrl && wa == scgsr_pkg::ADDR_PIN) ? pin_word :
      (pg_ctrl && wa == scgsr_pkg::ADDR_CONFIG) ? {15'h0000, cal_mode_ff} :
      (pg_ctrl && wa == scgsr_pkg::ADDR_SLEEP) ? slp_word :
      (pg_user && scr_hit) ? scratch_ff[scr_idx] :
      (pg_data && wa == scgsr_pkg::ADDR_TIME_MS) ? ms_word :
      (pg_data && wa == scgsr_pkg::ADDR_TIME_DH) ? dh_word :
      (pg_data && wa == scgsr_pkg::ADDR_TIME_YM) ? ym_word : 16'h0000;

   // Read answer is shifted out during the following frame
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_ff <= '0;
      end else if (rd) begin
         rd_ff <= rd_word;
      end
   end

   assign spi.rd_data = rd_ff;
endmodule

//--- sim/scgsr_checker.sv
// Checker of the pin and power-mode outputs of the system-control block.
// Assumes the pin function select keeps its reset value during the run.
`timescale 1ns/100ps
module scgsr_checker (
   input wire logic i_ref_clk, // clock
   input wire logic i_rst_n, // reset
   input wire logic i_spi_cs_n, // select
   input wire logic [3:0] o_gpio_out, // levels
   input wire logic [3:0] o_gpio_oe, // enables
   input wire logic o_sleep, // sleep
   input wire logic o_power_down // power-down
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   one_mode_a: assert property (!(o_sleep && o_power_down))
      else $error("sleep and power-down together");
   sleep_entry_a: assert property ($rose(o_sleep) |-> $past(i_spi_cs_n, 2))
      else $error("sleep entered with select low");
   pdown_entry_a: assert property ($rose(o_power_down) |-> $past(i_spi_cs_n, 2))
      else $error("power-down entered with select low");
   sleep_wake_a: assert property (o_sleep && $fell(i_spi_cs_n) |-> ##[1:6] !o_sleep)
      else $error("no wake from sleep");
   pdown_wake_a: assert property (o_power_down && $fell(i_spi_cs_n) |-> ##[1:6] !o_power_down)
      else $error("no wake from power-down");
   pin_owned_a: assert property (!o_gpio_oe[1])
      else $error("owned pin driven");
   level_write_a: assert property ($changed(o_gpio_out) |-> !$past(i_spi_cs_n, 2))
      else $error("levels moved without a frame");
   dir_write_a: assert property ($changed(o_gpio_oe) |-> !$past(i_spi_cs_n, 2))
      else $error("enables moved without a frame");
   cover property ($rose(o_sleep));
   cover property ($rose(o_power_down));
   cover property (o_gpio_oe == 4'hD);
endmodule
bind scgsr_top scgsr_checker chk_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
   .i_spi_cs_n(i_spi_cs_n), .o_gpio_out(o_gpio_out), .o_gpio_oe(o_gpio_oe),
   .o_sleep(o_sleep), .o_power_down(o_power_down));

//--- sim/scgsr_host.sv
// Host serial master model, mode 3, 16-bit frames, MSB first.
// Assumes the reference clock is fed in; pins move on its falling edge.
`timescale 1ns/100ps
module scgsr_host (
   input wire logic i_clk, // reference clock
   input wire logic i_miso, // data from block
   output logic o_cs_n = 1'b1, // select
   output logic o_sclk = 1'b1, // serial clock
   output logic o_mosi = 1'b0 // data to block
);
   task automatic gap(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      o_cs_n = 1'b0;
      gap(5);
      for (int i = 15; i >= 0; i--) begin
         o_sclk = 1'b0;
         o_mosi = w[i];
         gap(5);
         r[i] = i_miso;
         o_sclk = 1'b1;
         gap(5);
      end
      gap(10);
      o_cs_n = 1'b1;
      // Released line shows no stale bit
      o_mosi = ~o_mosi;
      gap(10);
   endtask
endmodule

//--- sim/test_system_control_gpio_sleep_rtc.sv
// Bench for the system-control block: pins, scratch words, power modes, clock.
// Assumes the host model owns the serial pins; one second is shortened to 1000 clocks.
`timescale 1ns/100ps
module test_system_control_gpio_sleep_rtc;
   localparam int TICK = 1000;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cs_n, sclk, mosi, miso, slp, pdn;
   logic [3:0] gin = 4'hA;
   logic [3:0] gout, goe;
   logic [15:0] rd, r;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   always #50 clk = ~clk;
   scgsr_top #(.P_TICK_CYCLES(TICK)) dut_u (.i_ref_clk(clk), .i_rst_n(rst_n),
      .i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_spi_din(mosi), .o_spi_dout(miso),
      .i_gpio_in(gin), .o_gpio_out(gout), .o_gpio_oe(goe), .o_sleep(slp),
      .o_power_down(pdn));
   scgsr_host host_u (.i_clk(clk), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_mosi(mosi));
   task automatic print_verdict;
      if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic do_reset;
      rst_n = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (5) @(negedge clk);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host_u.xfer({1'b1, a, d}, r);
   endtask
   // Read answer arrives on the following frame
   task automatic rdw(input logic [6:0] a);
      host_u.xfer({1'b0, a, 8'h00}, r);
      host_u.xfer(16'h0000, rd);
   endtask
   task automatic t_clock;
      logic [7:0] t [6] = '{8'h0A, 8'h14, 8'h05, 8'h07, 8'h03, 8'h18};
      rdw(7'h78);
      chk(rd, 16'h0000);
      repeat (TICK) @(negedge clk);
      rdw(7'h78);
      chk(rd, 16'h0001);
      wr(7'h00, 8'h03);
      wr(7'h0A, 8'h01);
      wr(7'h00, 8'h00);
      for (int i = 0; i < 6; i++) wr(7'h78 + 7'(i), t[i]);
      rdw(7'h7C);
      chk(rd, 16'h0000);
      repeat (TICK) @(negedge clk);
      rdw(7'h7C);
      chk(rd & 16'h7F0F, 16'h1803);
      rdw(7'h7A);
      chk(rd & 16'h1F3F, 16'h0705);
   endtask
   task automatic t_pins;
      wr(7'h00, 8'h03);
      rdw(7'h08);
      chk({8'h00, rd[7:0]}, 16'h00A0);
      wr(7'h08, 8'h15);
      chk({12'h000, goe}, 16'h0005);
      chk({12'h000, gout & goe}, 16'h0001);
      wr(7'h08, 8'hAF);
      chk({12'h000, goe}, 16'h000D);
      chk({12'h000, gout & goe}, 16'h0008);
      gin = 4'h5;
      rdw(7'h08);
      chk({8'h00, rd[7:0]}, 16'h005F);
   endtask
   task automatic t_scratch;
      wr(7'h00, 8'h02);
      for (int i = 0; i < 8; i++) wr(7'h74 + 7'(i), 8'hA5 ^ 8'(i * 17));
      for (int i = 0; i < 4; i++) begin
         rdw(7'h74 + 7'(2 * i));
         chk(rd, {8'hA5 ^ 8'(i * 34 + 17), 8'hA5 ^ 8'(i * 34)});
      end
   endtask
   task automatic t_sleep;
      int n = 0;
      wr(7'h00, 8'h03);
      wr(7'h10, 8'h00);
      wr(7'h11, 8'h01);
      repeat (3000) @(negedge clk);
      chk({15'h0, slp}, 16'h0001);
      host_u.xfer(16'h0000, r);
      chk({15'h0, slp}, 16'h0000);
      chk({12'h0, goe}, 16'h000D);
      wr(7'h10, 8'h02);
      wr(7'h11, 8'h01);
      chk({15'h0, slp}, 16'h0001);
      while (slp === 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      chk({15'h0, n > 900 && n < 2100}, 16'h0001);
      wr(7'h11, 8'h03);
      chk({14'h0, slp, pdn}, 16'h0002);
      host_u.xfer(16'h0000, r);
      wr(7'h11, 8'h02);
      chk({14'h0, slp, pdn}, 16'h0001);
      host_u.xfer(16'h0000, r);
      chk({14'h0, slp, pdn}, 16'h0000);
      chk({12'h0, goe}, 16'h0000);
      wr(7'h00, 8'h03);
      wr(7'h11, 8'h01);
      chk({15'h0, slp}, 16'h0001);
      do_reset();
      chk({14'h0, slp, pdn}, 16'h0000);
   endtask
   initial begin
      do_reset();
      t_clock();
      t_pins();
      t_scratch();
      t_sleep();
      print_verdict();
   end
endmodule
